/* File: hdl/chsi_defs.vh */
`ifndef CHSI_DEFS_VH
`define CHSI_DEFS_VH

// register byte addresses (word aligned)
`define CHSI_ADDR_W          6
`define CHSI_OFS_EVENT       6'h00
`define CHSI_OFS_LINE        6'h04
`define CHSI_OFS_MASK        6'h08
`define CHSI_OFS_CTRL        6'h0c
`define CHSI_OFS_TIMEOUT     6'h10
`define CHSI_OFS_BLKCNT      6'h14
`define CHSI_OFS_BLKLEN      6'h18
`define CHSI_OFS_REMAIN      6'h1c
`define CHSI_OFS_RXDATA      6'h20

// event_status bit positions
`define CHSI_EV_W            12
`define CHSI_EV_DATA_DONE    0
`define CHSI_EV_BUSY_DONE    1
`define CHSI_EV_RESP_DONE    2
`define CHSI_EV_READ_TO      3
`define CHSI_EV_RESP_TO      4
`define CHSI_EV_WRITE_CRC    5
`define CHSI_EV_READ_CRC     6
`define CHSI_EV_RESP_CRC     7
`define CHSI_EV_TX_READY     9
`define CHSI_EV_RX_READY     10
`define CHSI_EV_DATA3_EDGE   11
`define CHSI_EV_XFER_DONE    12
`define CHSI_EVX_W           13

// line_status bit positions
`define CHSI_LS_BUSY         0
`define CHSI_LS_TX_EMPTY     1
`define CHSI_LS_RX_FULL      2
`define CHSI_LS_CLK_STOP     3
`define CHSI_LS_DATA3        4

// control register fields
`define CHSI_CT_EDGE_LO      0
`define CHSI_CT_EDGE_HI      1
`define CHSI_CT_FIFO_SEL     2
`define CHSI_CT_BUSY_EXP     3

// edge select codes
`define CHSI_EDGE_OFF        2'h0
`define CHSI_EDGE_RISE       2'h1
`define CHSI_EDGE_FALL       2'h2
`define CHSI_EDGE_BOTH       2'h3

// fifo thresholds in bytes
`define CHSI_FIFO_W          7
`define CHSI_THR_LOW         7'h10
`define CHSI_THR_HIGH        7'h20

// reset values
`define CHSI_RST_MASK        13'h0000
`define CHSI_RST_CTRL        4'h0
`define CHSI_RST_TIMEOUT     8'h00
`define CHSI_RST_BLK         16'h0000

`endif

/* File: hdl/chsi_status_irq.v */
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`include "chsi_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module chsi_status_irq
(
    input  wire                     ref_clk_i,
    input  wire                     srst_i,
    // avalon-mm slave
    input  wire [`CHSI_ADDR_W-1:0]  avs_address_i,
    input  wire                     avs_read_i,
    input  wire                     avs_write_i,
    input  wire [31:0]              avs_writedata_i,
    input  wire [3:0]               avs_byteenable_i,
    output reg  [31:0]              avs_readdata_o,
    output reg                      avs_waitrequest_o,
    // pins from the card
    input  wire                     card_data3_pin_i,
    input  wire                     card_clock_pin_i,
    // events from command engine
    input  wire                     cmd_start_i,
    input  wire                     cmd_sent_i,
    input  wire                     cmd_resp_expected_i,
    input  wire                     resp_received_i,
    input  wire                     resp_crc_bad_i,
    input  wire                     card_busy_i,
    // events from data engine
    input  wire                     data_start_i,
    input  wire                     data_is_write_i,
    input  wire                     byte_moved_i,
    input  wire                     read_crc_bad_i,
    input  wire                     write_crc_bad_i,
    input  wire                     data_crc_checked_i,
    input  wire                     write_sent_i,
    input  wire                     read_timeout_i,
    input  wire                     block_done_i,
    input  wire [`CHSI_FIFO_W-1:0]  fifo_level_i,
    input  wire                     tx_shift_empty_i,
    input  wire                     rx_shift_full_i,
    input  wire                     card_clock_stopped_i,
    // outputs
    output reg                      irq_o,
    output reg                      transfer_done_o,
    output reg                      busy_expected_o,
    output reg                      rx_data_read_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg [1:0] data3_sync;
    reg [1:0] clk_sync;
    reg       data3_prev;
    reg       clk_prev;

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            data3_sync <= 2'h0;
            clk_sync   <= 2'h0;
            data3_prev <= 1'b0;
            clk_prev   <= 1'b0;
        end
        else
        begin
            data3_sync <= {data3_sync[0], card_data3_pin_i};
            clk_sync   <= {clk_sync[0], card_clock_pin_i};
            data3_prev <= data3_sync[1];
            clk_prev   <= clk_sync[1];
        end
    end

    wire data3_level = data3_sync[1];
    wire card_clk_rise = clk_sync[1] & ~clk_prev;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    reg [`CHSI_EVX_W-1:0] event_enable_mask;
    reg [3:0]             ctrl;
    reg [7:0]             resp_timeout_cfg;
    reg [15:0]            block_count_cfg;
    reg [15:0]            block_length_cfg;
    reg [15:0]            blocks_remaining_count;

    wire [1:0] data3_edge_select  = ctrl[`CHSI_CT_EDGE_HI:`CHSI_CT_EDGE_LO];
    wire       fifo_threshold_sel = ctrl[`CHSI_CT_FIFO_SEL];
    wire       busy_expected      = ctrl[`CHSI_CT_BUSY_EXP];

    wire wr_acc = avs_write_i & ~avs_waitrequest_o;
    wire rd_acc = avs_read_i & avs_waitrequest_o;

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    wire [`CHSI_FIFO_W-1:0] threshold = fifo_threshold_sel ? `CHSI_THR_HIGH
                                                           : `CHSI_THR_LOW;
    wire rx_ready_ev = (fifo_level_i > threshold);
    wire tx_ready_ev = (fifo_level_i < threshold);

    reg  edge_ev;
    always @*
    begin
        case (data3_edge_select)
            `CHSI_EDGE_RISE: edge_ev = data3_level & ~data3_prev;
            `CHSI_EDGE_FALL: edge_ev = ~data3_level & data3_prev;
            `CHSI_EDGE_BOTH: edge_ev = data3_level ^ data3_prev;
            default:         edge_ev = 1'b0;
        endcase
    end

    // response time-out counted in card clock rising edges
    reg [7:0] resp_wait_cnt;
    reg       resp_waiting;
    wire      resp_to_ev = resp_waiting & card_clk_rise & (resp_timeout_cfg != 8'h00)
                           & (resp_wait_cnt == resp_timeout_cfg - 8'h01);

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            resp_waiting  <= 1'b0;
            resp_wait_cnt <= 8'h00;
        end
        else if (cmd_sent_i & cmd_resp_expected_i)
        begin
            resp_waiting  <= 1'b1;
            resp_wait_cnt <= 8'h00;
        end
        else if (resp_received_i | resp_to_ev)
            resp_waiting  <= 1'b0;
        else if (resp_waiting & card_clk_rise)
            resp_wait_cnt <= resp_wait_cnt + 8'h01;
    end

    // busy tracking: done once busy has not or no longer is asserted
    reg busy_watch;
    wire busy_done_ev = busy_watch & ~card_busy_i;
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
            busy_watch <= 1'b0;
        else if (cmd_sent_i & busy_expected)
            busy_watch <= 1'b1;
        else if (busy_done_ev)
            busy_watch <= 1'b0;
    end

    // byte counting and transfer completion
    reg [31:0] bytes_left;
    reg        xfer_active;
    reg        data_pending;
    wire       last_byte = xfer_active & byte_moved_i & (bytes_left == 32'h1);
    wire       data_done_ev = data_pending
                            & (data_is_write_i ? write_sent_i
                                               : (data_crc_checked_i & ~read_crc_bad_i));

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            bytes_left   <= 32'h0;
            xfer_active  <= 1'b0;
            data_pending <= 1'b0;
        end
        else if (data_start_i)
        begin
            bytes_left   <= block_count_cfg * block_length_cfg;
            xfer_active  <= 1'b1;
            data_pending <= 1'b0;
        end
        else
        begin
            if (xfer_active & byte_moved_i)
                bytes_left <= bytes_left - 32'h1;
            if (last_byte)
            begin
                xfer_active  <= 1'b0;
                data_pending <= 1'b1;
            end
            else if (data_done_ev)
                data_pending <= 1'b0;
        end
    end

    // remaining block counter
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
            blocks_remaining_count <= `CHSI_RST_BLK;
        else if (data_start_i)
            blocks_remaining_count <= block_count_cfg;
        else if (block_done_i & (blocks_remaining_count != 16'h0))
            blocks_remaining_count <= blocks_remaining_count - 16'h1;
    end

    // ------------------------------------------------------------
    // event status flags
    // ------------------------------------------------------------
    wire [`CHSI_EVX_W-1:0] events;
    assign events[`CHSI_EV_DATA_DONE]  = data_done_ev;
    assign events[`CHSI_EV_BUSY_DONE]  = busy_done_ev;
    assign events[`CHSI_EV_RESP_DONE]  = (resp_received_i & ~resp_crc_bad_i)
                                       | (cmd_sent_i & ~cmd_resp_expected_i);
    assign events[`CHSI_EV_READ_TO]    = read_timeout_i;
    assign events[`CHSI_EV_RESP_TO]    = resp_to_ev;
    assign events[`CHSI_EV_WRITE_CRC]  = write_crc_bad_i;
    assign events[`CHSI_EV_READ_CRC]   = read_crc_bad_i;
    assign events[`CHSI_EV_RESP_CRC]   = resp_received_i & resp_crc_bad_i;
    assign events[8]                   = 1'b0;
    assign events[`CHSI_EV_TX_READY]   = tx_ready_ev;
    assign events[`CHSI_EV_RX_READY]   = rx_ready_ev;
    assign events[`CHSI_EV_DATA3_EDGE] = edge_ev;
    assign events[`CHSI_EV_XFER_DONE]  = last_byte;

    reg [`CHSI_EVX_W-1:0] event_status;
    wire ev_read = rd_acc & (avs_address_i == `CHSI_OFS_EVENT);
    wire rx_read = rd_acc & (avs_address_i == `CHSI_OFS_RXDATA);

    genvar gi;
    generate
        for (gi = 0; gi < `CHSI_EVX_W; gi = gi + 1)
        begin : g_flag
            wire clr = ev_read | ((gi == `CHSI_EV_RX_READY) & rx_read);
            always @(posedge ref_clk_i)
            begin
                if (srst_i)
                    event_status[gi] <= 1'b0;
                else if (events[gi])
                    event_status[gi] <= 1'b1;
                else if (clr)
                    event_status[gi] <= 1'b0;
            end
        end
    endgenerate

    wire [`CHSI_EVX_W-1:0] next_pending = event_status & event_enable_mask;

    // ------------------------------------------------------------
    // register access
    // ------------------------------------------------------------
    wire [7:0] line_status = {3'h0,
                              data3_level,
                              card_clock_stopped_i,
                              rx_shift_full_i,
                              tx_shift_empty_i,
                              busy_watch & card_busy_i | card_busy_i};

    reg [31:0] next_readdata;
    always @*
    begin
        case (avs_address_i)
            `CHSI_OFS_EVENT:   next_readdata = {19'h0, event_status};
            `CHSI_OFS_LINE:    next_readdata = {24'h0, line_status};
            `CHSI_OFS_MASK:    next_readdata = {19'h0, event_enable_mask};
            `CHSI_OFS_CTRL:    next_readdata = {28'h0, ctrl};
            `CHSI_OFS_TIMEOUT: next_readdata = {24'h0, resp_timeout_cfg};
            `CHSI_OFS_BLKCNT:  next_readdata = {16'h0, block_count_cfg};
            `CHSI_OFS_BLKLEN:  next_readdata = {16'h0, block_length_cfg};
            `CHSI_OFS_REMAIN:  next_readdata = {16'h0, blocks_remaining_count};
            default:           next_readdata = 32'h0;
        endcase
    end

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            event_enable_mask <= `CHSI_RST_MASK;
            ctrl              <= `CHSI_RST_CTRL;
            resp_timeout_cfg  <= `CHSI_RST_TIMEOUT;
            block_count_cfg   <= `CHSI_RST_BLK;
            block_length_cfg  <= `CHSI_RST_BLK;
        end
        else if (wr_acc)
        begin
            case (avs_address_i)
                `CHSI_OFS_MASK:
                begin
                    if (avs_byteenable_i[0])
                        event_enable_mask[7:0] <= avs_writedata_i[7:0];
                    if (avs_byteenable_i[1])
                        event_enable_mask[12:8] <= avs_writedata_i[12:8];
                end
                `CHSI_OFS_CTRL:
                    if (avs_byteenable_i[0])
                        ctrl <= avs_writedata_i[3:0];
                `CHSI_OFS_TIMEOUT:
                    if (avs_byteenable_i[0])
                        resp_timeout_cfg <= avs_writedata_i[7:0];
                `CHSI_OFS_BLKCNT:
                begin
                    if (avs_byteenable_i[0])
                        block_count_cfg[7:0] <= avs_writedata_i[7:0];
                    if (avs_byteenable_i[1])
                        block_count_cfg[15:8] <= avs_writedata_i[15:8];
                end
                `CHSI_OFS_BLKLEN:
                begin
                    if (avs_byteenable_i[0])
                        block_length_cfg[7:0] <= avs_writedata_i[7:0];
                    if (avs_byteenable_i[1])
                        block_length_cfg[15:8] <= avs_writedata_i[15:8];
                end
                default:
                    ctrl <= ctrl;
            endcase
        end
    end

    // ------------------------------------------------------------
    // bus answer and outputs
    // ------------------------------------------------------------
    // waitrequest idles high; one low cycle answers each request
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0;
            irq_o             <= 1'b0;
            transfer_done_o   <= 1'b0;
            busy_expected_o   <= 1'b0;
            rx_data_read_o    <= 1'b0;
        end
        else
        begin
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
            if (rd_acc)
                avs_readdata_o <= next_readdata;
            irq_o           <= |next_pending;
            transfer_done_o <= last_byte;
            busy_expected_o <= busy_expected;
            rx_data_read_o  <= rx_read;
        end
    end

endmodule

`default_nettype wire

/* File: verif/chsi_card_model.sv */
`timescale 1ns/100ps
`default_nettype none

module chsi_card_model
(
    output logic card_data3_pin_o,
    output logic card_clock_pin_o
);
    initial
    begin
        card_data3_pin_o = 1'b0;
        card_clock_pin_o = 1'b0;
    end

    task automatic set_d3(input logic v);
        card_data3_pin_o = v;
    endtask

    // card clock only toggles inside a frame, 64 ns period, idles low
    task automatic frame(input int n);
        repeat (n)
        begin
            #32 card_clock_pin_o = 1'b1;
            #32 card_clock_pin_o = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

/* File: verif/chsi_status_irq_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module chsi_status_irq_bench;
    logic        ref_clk_i = 1'b0;
    logic        srst_i    = 1'b1;
    logic [5:0]  addr      = 6'h00;
    logic        rd_en     = 1'b0;
    logic        wr_en     = 1'b0;
    logic [31:0] wdata     = 32'h0;
    logic [8:0]  ev        = 9'h000;
    logic        resp_crc  = 1'b0;
    logic        resp_exp  = 1'b0;
    logic        busy      = 1'b0;
    logic [6:0]  level     = 7'h10;
    logic [2:0]  lv        = 3'h0;
    logic        seen      = 1'b0;
    logic        rxs       = 1'b0;
    logic        dwr       = 1'b1;
    logic        crc_chk   = 1'b0;
    logic [3:0]  be        = 4'hf;
    logic [31:0] d;
    wire  [31:0] rdata;
    wire         waitreq, irq, xdone, d3, cclk, bexp, rxrd;
    int          errors = 0;
    int          check_count = 0;
    // rows: {resp crc bad, resp expected, event pulses, expected event status}
    logic [23:0] rows [7] = '{{2'h0, 9'h001, 13'h0040}, {2'h0, 9'h002, 13'h0020},
        {2'h0, 9'h004, 13'h0008}, {2'h0, 9'h008, 13'h0004}, {2'h2, 9'h008, 13'h0080},
        {2'h0, 9'h010, 13'h0004}, {2'h1, 9'h010, 13'h0000}};

    initial forever #2.5 ref_clk_i = ~ref_clk_i;

    chsi_card_model i_card (.card_data3_pin_o(d3), .card_clock_pin_o(cclk));

    chsi_status_irq i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .avs_address_i(addr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .card_data3_pin_i(d3), .card_clock_pin_i(cclk), .cmd_start_i(1'b0),
        .cmd_sent_i(ev[4]), .cmd_resp_expected_i(resp_exp), .resp_received_i(ev[3]),
        .resp_crc_bad_i(resp_crc), .card_busy_i(busy), .data_start_i(ev[6]),
        .data_is_write_i(dwr), .byte_moved_i(ev[5]), .read_crc_bad_i(ev[0]),
        .write_crc_bad_i(ev[1]), .data_crc_checked_i(crc_chk), .write_sent_i(ev[7]),
        .read_timeout_i(ev[2]), .block_done_i(ev[8]), .fifo_level_i(level),
        .tx_shift_empty_i(lv[0]), .rx_shift_full_i(lv[1]), .card_clock_stopped_i(lv[2]),
        .irq_o(irq), .transfer_done_o(xdone), .busy_expected_o(bexp), .rx_data_read_o(rxrd));

    always @(posedge ref_clk_i)
    begin
        if (xdone === 1'b1)
            seen <= 1'b1;
        if (rxrd === 1'b1)
            rxs <= 1'b1;
    end

    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] wv,
                       output logic [31:0] v);
        addr <= a;
        wdata <= wv;
        rd_en <= !w;
        wr_en <= w;
        @(posedge ref_clk_i);
        while (waitreq !== 1'b0)
            @(posedge ref_clk_i);
        v = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic pulse(input logic [8:0] v);
        ev <= v;
        @(posedge ref_clk_i);
        ev <= 9'h000;
        repeat (3) @(posedge ref_clk_i);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #300000;
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        end_of_test;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(posedge ref_clk_i);
        acc(0, 6'h08, 0, d); chk(d, 32'h0);
        acc(0, 6'h0c, 0, d); chk(d, 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            {resp_crc, resp_exp} <= rows[i][23:22];
            pulse(rows[i][21:13]);
            acc(0, 6'h00, 0, d); chk(d, {19'h0, rows[i][12:0]});
            acc(0, 6'h00, 0, d); chk(d, 32'h0);
        end
        resp_exp <= 1'b0;
        acc(1, 6'h08, 32'h40, d);
        pulse(9'h002); chk({31'h0, irq}, 32'h0);
        pulse(9'h001); chk({31'h0, irq}, 32'h1);
        acc(0, 6'h00, 0, d);
        repeat (3) @(posedge ref_clk_i);
        chk({31'h0, irq}, 32'h0);
        acc(1, 6'h08, 32'h0, d);
        fork
            acc(0, 6'h00, 0, d);
            pulse(9'h001);
        join
        acc(0, 6'h00, 0, d); chk(d, 32'h40);
        for (int i = 0; i < 4; i++)
        begin
            acc(1, 6'h0c, {29'h0, i[1], 2'h0}, d);
            level <= i[1] ? (i[0] ? 7'h1f : 7'h21) : (i[0] ? 7'h0f : 7'h11);
            repeat (4) @(posedge ref_clk_i);
            acc(0, 6'h00, 0, d);
            acc(0, 6'h00, 0, d); chk(d, i[0] ? 32'h200 : 32'h400);
        end
        level <= 7'h10;
        acc(1, 6'h0c, 32'h0, d);
        acc(0, 6'h00, 0, d);
        level <= 7'h11;
        repeat (4) @(posedge ref_clk_i);
        level <= 7'h10;
        repeat (4) @(posedge ref_clk_i);
        chk({31'h0, rxs}, 32'h0);
        acc(0, 6'h20, 0, d); chk(d, 32'h0);
        chk({31'h0, rxs}, 32'h1);
        acc(0, 6'h00, 0, d); chk(d, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            acc(1, 6'h0c, i, d);
            i_card.set_d3(1'b1);
            repeat (8) @(posedge ref_clk_i);
            i_card.set_d3(1'b0);
            repeat (8) @(posedge ref_clk_i);
            acc(0, 6'h00, 0, d); chk(d, i != 0 ? 32'h800 : 32'h0);
        end
        acc(1, 6'h0c, 32'h0, d);
        lv <= 3'h5;
        i_card.set_d3(1'b1);
        repeat (10) @(posedge ref_clk_i);
        acc(0, 6'h04, 0, d); chk(d, 32'h1a);
        i_card.set_d3(1'b0);
        lv <= 3'h0;
        acc(1, 6'h0c, 32'h8, d);
        resp_exp <= 1'b1;
        pulse(9'h010);
        chk({31'h0, bexp}, 32'h1);
        acc(0, 6'h00, 0, d); chk(d, 32'h2);
        busy <= 1'b1;
        pulse(9'h010);
        acc(0, 6'h00, 0, d); chk(d, 32'h0);
        acc(0, 6'h04, 0, d); chk(d, 32'h1);
        busy <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        acc(0, 6'h00, 0, d); chk(d, 32'h2);
        acc(1, 6'h0c, 32'h0, d);
        acc(1, 6'h10, 32'h3, d);
        pulse(9'h010);
        i_card.frame(2);
        repeat (8) @(posedge ref_clk_i);
        acc(0, 6'h00, 0, d); chk(d, 32'h0);
        i_card.frame(1);
        repeat (8) @(posedge ref_clk_i);
        acc(0, 6'h00, 0, d); chk(d, 32'h10);
        acc(1, 6'h10, 32'h0, d);
        resp_exp <= 1'b0;
        acc(1, 6'h14, 32'h1, d);
        acc(1, 6'h18, 32'h2, d);
        pulse(9'h040);
        acc(0, 6'h1c, 0, d); chk(d, 32'h1);
        acc(1, 6'h1c, 32'h5, d);
        acc(0, 6'h1c, 0, d); chk(d, 32'h1);
        pulse(9'h020);
        chk({31'h0, seen}, 32'h0);
        pulse(9'h020);
        chk({31'h0, seen}, 32'h1);
        acc(0, 6'h00, 0, d); chk(d, 32'h1000);
        pulse(9'h080);
        acc(0, 6'h00, 0, d); chk(d, 32'h1);
        dwr <= 1'b0;
        pulse(9'h040);
        pulse(9'h020);
        pulse(9'h020);
        acc(0, 6'h00, 0, d); chk(d, 32'h1000);
        crc_chk <= 1'b1;
        @(posedge ref_clk_i);
        crc_chk <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        acc(0, 6'h00, 0, d); chk(d, 32'h1);
        pulse(9'h100);
        acc(0, 6'h1c, 0, d); chk(d, 32'h0);
        acc(0, 6'h3c, 0, d); chk(d, 32'h0);
        acc(1, 6'h08, 32'h1fff, d);
        acc(0, 6'h08, 0, d); chk(d, 32'h1fff);
        be <= 4'h2;
        acc(1, 6'h08, 32'h0, d);
        be <= 4'hf;
        acc(0, 6'h08, 0, d); chk(d, 32'h00ff);
        srst_i <= 1'b1;
        repeat (16) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(posedge ref_clk_i);
        acc(0, 6'h08, 0, d); chk(d, 32'h0);
        end_of_test;
    end
endmodule

`default_nettype wire

/* File: verif/chsi_status_irq_chk.sv */
`timescale 1ns/100ps
`default_nettype none

module chsi_status_irq_chk
(
    input wire logic        ref_clk_i,
    input wire logic        srst_i,
    input wire logic [5:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        card_data3_pin_i,
    input wire logic        tx_shift_empty_i,
    input wire logic        rx_shift_full_i,
    input wire logic        card_clock_stopped_i,
    input wire logic        byte_moved_i,
    input wire logic        transfer_done_o,
    input wire logic        busy_expected_o,
    input wire logic        rx_data_read_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    wire       req     = avs_read_i | avs_write_i;
    wire       rd_rx   = avs_read_i && avs_address_i == 6'h20;
    wire       wr_ctrl = avs_write_i && avs_address_i == 6'h0c;
    wire [3:0] lvl     = {card_data3_pin_i, card_clock_stopped_i, rx_shift_full_i, tx_shift_empty_i};
    logic [3:0] lvl_q;
    logic [2:0] quiet;

    // counts cycles, up to 7, since any line level other than busy last moved
    always_ff @(posedge ref_clk_i)
    begin
        lvl_q <= lvl;
        if (srst_i || lvl_q != lvl)
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end

    chk_wait_answer: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("no answer one cycle after request");
    chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low longer than one cycle");
    chk_wait_idle: assert property (!req && avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer without request");
    chk_busy_exp_src: assert property ($changed(busy_expected_o) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
        else $error("busy expected changed without control write");
    chk_rx_strobe: assert property (rx_data_read_o |-> ($past(rd_rx) || $past(rd_rx, 2) || $past(rd_rx, 3)) ##1 !rx_data_read_o)
        else $error("rx data strobe without read or too long");
    chk_rx_zero: assert property (rd_rx && !avs_waitrequest_o |-> avs_readdata_o == 32'h0)
        else $error("rx data strobe address read nonzero");
    chk_xfer_pulse: assert property (transfer_done_o |-> $past(byte_moved_i) ##1 !transfer_done_o)
        else $error("transfer done without byte or too long");
    chk_line_level: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 6'h04 && quiet == 3'h7 |-> avs_readdata_o[4:1] == lvl)
        else $error("line status differs from levels");
endmodule

bind chsi_status_irq chsi_status_irq_chk i_chk (.ref_clk_i, .srst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .card_data3_pin_i, .tx_shift_empty_i,
    .rx_shift_full_i, .card_clock_stopped_i, .byte_moved_i, .transfer_done_o, .busy_expected_o,
    .rx_data_read_o);

`default_nettype wire
